// ### verif/cvt_analog_model.sv
/* Analog input behind the comparator, with sample and hold.
   Assumes the block drives the trial code and the sampling strobe. */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Sample and hold
// ----------------------------------------
module cvt_analog_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sample_i,
  input  wire logic [10:0] level_i,
  input  wire logic [10:0] code_i,
  output logic             comp_o
);
  logic [10:0] held;
  // Input is only seen while connected, so late changes must not leak in
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) held <= 11'h000;
    else if (sample_i) held <= level_i;
  end
  assign comp_o = held >= code_i;
endmodule // cvt_analog_model
`default_nettype wire

// ### verif/cvt_top_props.sv
/* Checker of the converter control outputs against its inputs.
   Assumes it is bound to cvt_top and sees only that module's ports. */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port relations
// ----------------------------------------
module cvt_top_props (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic [2:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        wait_mode_i,
  input wire logic        irq_o,
  input wire logic        wake_o,
  input wire logic        sample_o,
  input wire logic [10:0] dac_code_o,
  input wire logic        conv_active_o,
  input wire logic        async_clk_en_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_wake_gate: assert property (wake_o == (irq_o && wait_mode_i)) else $error("wake gating");
  a_rdata_zero: assert property ($past(ce_i) && (!$past(rd_i) || $past(addr_i) == 3'h7)
    |-> rdata_o == 8'h00) else $error("read data outside read");
  a_sample_active: assert property (sample_o |-> conv_active_o) else $error("sample while idle");
  a_sample_first: assert property ($rose(conv_active_o) |->
    ##[1:600] (sample_o || !conv_active_o)) else $error("no sampling after start");
  a_code_held: assert property (sample_o && $past(sample_o) |-> $stable(dac_code_o))
    else $error("trial code moved in sampling");
  a_sample_len: assert property ($rose(sample_o) |-> (sample_o || !conv_active_o) [*7])
    else $error("sampling too short");
  a_async_en: assert property (async_clk_en_o |-> conv_active_o) else $error("oscillator while idle");
  a_irq_finish: assert property ($rose(irq_o) |-> $past(conv_active_o)) else $error("irq without finish");
  a_irq_read_clr: assert property ($past(ce_i && rd_i && addr_i == 3'h3 && !conv_active_o) |-> !irq_o)
    else $error("flag kept after read");
  c_irq: cover property ($rose(irq_o));
  c_wake: cover property (wake_o);
  c_async: cover property ($rose(async_clk_en_o));
endmodule // cvt_top_props

bind cvt_top cvt_top_props u_props (.mclk_i, .rst_n_i, .ce_i, .addr_i, .rd_i, .rdata_o, .wait_mode_i,
  .irq_o, .wake_o, .sample_o, .dac_code_o, .conv_active_o, .async_clk_en_o);
`default_nettype wire

// ### verif/cvt_top_tb.sv
/* Bench of the converter control block: timing sweep, repeats, hardware
   start and compare. Assumes the analog model answers the comparator. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
// ----------------------------------------
// Bench
// ----------------------------------------
module cvt_top_tb;
  logic        mclk_i = 0, rst_n_i = 0, wr = 0, rd = 0, trig = 0, alt = 0, wm = 0, dir;
  logic [2:0]  addr = 0;
  logic [7:0]  wd = 0, d, hi;
  logic [10:0] lvl = 0;
  logic [9:0]  r, cv, prev;
  logic [31:0] seed = 15427;
  logic [1:0]  sel, dv;
  wire  [7:0]  rdata;
  wire  [10:0] dac;
  wire  [4:0]  ch;
  wire         irq, wake, smp, act, aen, comp;
  int          fail_count = 0, tests_run = 0, n, p, t;
  cvt_top #(.STARTUP_CYC(4)) dut (.mclk_i, .rst_n_i, .ce_i(1'b1), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .hw_trig_i(trig), .alt_tick_i(alt), .comp_i(comp), .wait_mode_i(wm),
    .irq_o(irq), .wake_o(wake), .sample_o(smp), .channel_o(ch), .dac_code_o(dac), .conv_active_o(act),
    .async_clk_en_o(aen));
  cvt_analog_model u_ana (.mclk_i, .rst_n_i, .sample_i(smp), .level_i(lvl), .code_i(dac), .comp_o(comp));
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) alt <= ~alt;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Saturates at full scale instead of wrapping to zero
  function automatic logic [9:0] round10(logic [10:0] v);
    return (v == 11'h7ff) ? 10'h3ff : 10'((12'(v) + 12'h001) >> 1);
  endfunction
  function automatic logic [9:0] round8(logic [10:0] v);
    return (v[10:2] == 9'h1ff) ? 10'h0ff : 10'((10'(v[10:2]) + 10'h001) >> 1);
  endfunction
  function automatic int ticks(logic lng, logic ten, logic rep);
    return (lng ? 40 : 20) + (ten ? 3 : 0) - (rep ? 3 : 0);
  endfunction
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    addr <= a;
    wd <= v;
    wr <= 1;
    @(posedge mclk_i);
    wr <= 0;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1;
    @(posedge mclk_i);
    rd <= 0;
    #1 v = rdata;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic wait_on(input int k, output int c);
    c = 0;
    while (!(k == 0 ? irq === 1'b1 : k == 1 ? smp === 1'b1 : k == 2 ? smp === 1'b0 : act === 1'b0) && c < 3000) begin
      @(posedge mclk_i);
      #1;
      c++;
    end
    if (c >= 3000) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1;
    @(posedge mclk_i);
    rd_reg(3'h7, d);
    `CHK("unmapped", 8'h00, d)
    wr_reg(3'h1, 8'h00);
    for (int i = 0; i < 16; i++) begin
      sel = i[3:2];
      dv = 2'(rnd());
      lvl <= 11'(rnd());
      p = ((sel == 2'h0) ? 1 : 2) << dv;
      t = 5 + ticks(i[0], i[1], 0) * p + ((sel == 2'h3) ? 4 : 0);
      wr_reg(3'h6, {1'b0, dv, i[0], i[1], 1'b0, sel});
      wr_reg(3'h0, 8'h41);
      `CHK("async_en", sel == 2'h3, aen)
      `CHK("channel", 5'h01, ch)
      wait_on(0, n);
      `CHK("conv_time", 1, (n + 1 <= t) && (n + p + 5 >= t))
      rd_reg(3'h2, hi);
      rd_reg(3'h3, d);
      `CHK("result", i[1] ? round10(lvl) : round8(lvl), {hi[1:0], d})
      `CHK("flag_clear", 1'b0, irq)
    end
    wm <= 1;
    for (int i = 0; i < 4; i++) begin
      t = ticks(i[0], i[1], 1);
      wr_reg(3'h6, {3'h0, i[0], i[1], 3'h0});
      wr_reg(3'h0, 8'h61);
      wait_on(0, n);
      rd_reg(3'h3, d);
      wait_on(0, n);
      `CHK("repeat_time", 1, (n + 3 >= t) && (n + 1 <= t))
      `CHK("wake", 1'b1, wake)
      wr_reg(3'h0, 8'h1f);
      wait_on(3, n);
      `CHK("abort_idle", 1'b0, act)
    end
    wm <= 0;
    wr_reg(3'h1, 8'h40);
    wr_reg(3'h0, 8'h41);
    `CHK("hw_wait", 1'b0, act)
    trig <= 1;
    wait_on(0, n);
    `CHK("hw_done", 1'b1, irq)
    trig <= 0;
    rd_reg(3'h2, hi);
    rd_reg(3'h3, d);
    prev = {hi[1:0], d};
    wr_reg(3'h6, 8'h08);
    for (int i = 0; i < 24; i++) begin
      cv = 10'(rnd());
      dir = (i < 4) ? i[0] : 1'(rnd());
      lvl <= (i < 4) ? {cv, 1'b0} : 11'(rnd());
      wr_reg(3'h4, {6'h00, cv[9:8]});
      wr_reg(3'h5, cv[7:0]);
      wr_reg(3'h1, {2'b00, 1'b1, dir, 4'h0});
      wr_reg(3'h0, 8'h41);
      r = round10(lvl);
      wait_on(1, n);
      wait_on(2, n);
      lvl <= 11'(rnd());
      wait_on(3, n);
      `CHK("cmp_irq", dir ? r >= cv : r < cv, irq)
      rd_reg(3'h0, d);
      `CHK("cmp_flag", dir ? r >= cv : r < cv, d[7])
      if (dir ? r >= cv : r < cv) prev = r - cv;
      rd_reg(3'h2, hi);
      rd_reg(3'h3, d);
      `CHK("cmp_result", prev, {hi[1:0], d})
    end
    give_verdict();
  end
endmodule // cvt_top_tb
`default_nettype wire

// ### verilog/cvt_clkgen.sv
/*
  Conversion clock enable: source select, internal oscillator with startup
  delay, and divide by 1, 2, 4 or 8.
  Assumes the alternate clock arrives as a one-cycle enable on mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cvt_regs.svh"

module cvt_clkgen #(
  parameter int ASYNC_DIV   = 2,
  parameter int STARTUP_CYC = `CVT_ASYNC_STARTUP_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [1:0] div_i,
  input  wire logic       alt_tick_i,
  input  wire logic       async_en_i,
  output logic            tick_o,
  output logic            async_ready_o
);
  logic       half;
  logic [7:0] osc_cnt;
  logic [8:0] start_cnt;
  logic [2:0] div_cnt;
  logic [2:0] mask;
  logic       async_tick;
  logic       src_tick;

  assign async_ready_o = (start_cnt == 9'(STARTUP_CYC));
  assign async_tick    = async_en_i && async_ready_o && (osc_cnt == 8'(ASYNC_DIV - 1));
  // Source map: bus, bus halved, alternate, internal asynchronous  [R26]
  assign src_tick = (sel_i == 2'h0) ? 1'b1 :
                    (sel_i == 2'h1) ? half :
                    (sel_i == 2'h2) ? alt_tick_i : async_tick;  // [R21]
  assign mask     = {div_i == 2'h3, div_i[1], div_i != 2'h0};
  assign tick_o   = src_tick && ((div_cnt & mask) == mask);  // [R23]

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half      <= 1'b0;
      osc_cnt   <= 8'h00;
      start_cnt <= 9'h000;
      div_cnt   <= 3'h0;
    end else if (ce_i) begin
      half    <= ~half;
      div_cnt <= src_tick ? div_cnt + 3'h1 : div_cnt;
      if (!async_en_i) begin
        osc_cnt   <= 8'h00;
        start_cnt <= 9'h000;
      end else begin
        // Oscillator settles before its first edge  [R7]
        start_cnt <= async_ready_o ? start_cnt : start_cnt + 9'h001;
        osc_cnt   <= (async_tick || !async_ready_o) ? 8'h00 : osc_cnt + 8'h01;
      end
    end
  end
endmodule // cvt_clkgen

`default_nettype wire

// ### verilog/cvt_pkg.sv
/*
  Types of the converter control block.
  Assumes nothing beyond the register header.
*/
package cvt_pkg;

  // Gray codes along idle, setup, sample, convert, finish
  typedef enum logic [2:0] {
    CVT_IDLE    = 3'h0,
    CVT_SETUP   = 3'h1,
    CVT_SAMPLE  = 3'h3,
    CVT_CONVERT = 3'h2,
    CVT_FINISH  = 3'h6
  } cvt_state_e;

  typedef logic [10:0] cvt_code_t;

endpackage

// ### verilog/cvt_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  converter control block.
  Assumes a 40 MHz bus clock and an 8-bit register port.
*/
`ifndef CVT_REGS_SVH
`define CVT_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CVT_OFF_CTRL1         3'h0
`define CVT_OFF_CTRL2         3'h1
`define CVT_OFF_RESULT_HIGH   3'h2
`define CVT_OFF_RESULT_LOW    3'h3
`define CVT_OFF_CMP_HIGH      3'h4
`define CVT_OFF_CMP_LOW       3'h5
`define CVT_OFF_CONFIG        3'h6

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CVT_C1_FLAG           7
`define CVT_C1_IRQ_EN         6
`define CVT_C1_CONT           5
`define CVT_C2_ACTIVE         7
`define CVT_C2_HW_TRIG        6
`define CVT_C2_CMP_EN         5
`define CVT_C2_CMP_DIR        4
`define CVT_CFG_LOW_POWER     7
`define CVT_CFG_LONG_SAMPLE   4
`define CVT_CFG_TEN_BIT       3
`define CVT_CHANNEL_OFF       5'h1f
`define CVT_SEL_ASYNC         2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CVT_CLK_MHZ           40
`define CVT_ASYNC_STARTUP_NS  5000
`define CVT_ASYNC_STARTUP_CYC ((`CVT_ASYNC_STARTUP_NS * `CVT_CLK_MHZ) / 1000)
`define CVT_SETUP_BUS_CYC     6'h05
`define CVT_STARTUP_TICKS     6'h03
`define CVT_SAMPLE_SHORT      6'h07
`define CVT_SAMPLE_LONG       6'h1b
`define CVT_FINISH_8BIT       6'h01
`define CVT_FINISH_10BIT      6'h02

`endif

// ### verilog/cvt_sar.sv
/*
  Successive approximation engine: one trial bit per conversion clock.
  Assumes the comparator answer is valid one conversion clock after the
  trial code is presented.
*/
`timescale 1ns/100ps
`default_nettype none

module cvt_sar (
  input  wire logic   mclk_i,
  input  wire logic   rst_n_i,
  input  wire logic   ce_i,
  cvt_sar_if.engine   sar
);
  logic       busy;
  logic [3:0] idx;
  logic [3:0] last;

  // 8-bit mode resolves 9 bits at the top of the code
  assign last = sar.ten_bit ? 4'h0 : 4'h2;
  // Last trial tick; no spare bus cycle before finish
  assign sar.done = busy && sar.tick && (idx == last);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy     <= 1'b0;
      idx      <= 4'h0;
      sar.code <= 11'h000;
    end else if (ce_i) begin
      if (sar.start) begin
        busy     <= 1'b1;
        idx      <= 4'ha;
        sar.code <= 11'h400;
      end else if (busy && sar.tick) begin  // [R3]
        sar.code[idx] <= sar.comp;
        if (idx == last) begin
          busy     <= 1'b0;
        end else begin
          sar.code[idx - 4'h1] <= 1'b1;
          idx                  <= idx - 4'h1;
        end
      end
    end
  end
endmodule // cvt_sar

`default_nettype wire

// ### verilog/cvt_sar_if.sv
/*
  Interface between the conversion sequencer and the approximation engine.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none

interface cvt_sar_if;
  logic             start;
  logic             tick;
  logic             comp;
  logic             ten_bit;
  logic             done;
  cvt_pkg::cvt_code_t code;

  modport ctrl   (output start, output tick, output comp, output ten_bit, input done, input code);
  modport engine (input start, input tick, input comp, input ten_bit, output done, output code);
endinterface

`default_nettype wire

// ### verilog/cvt_top.sv
/*
  Successive approximation converter control: sequencing, conversion
  timing, result rounding, automatic compare and register port.
  Assumes synchronous inputs on mclk_i and a comparator answering the
  trial code on dac_code_o.
*/
// Design decisions made here: the placing of the registers and the strobed register port.
// Behaviour
// [R1] Leaving idle, conversion starts with sampling the selected channel.
// [R2] Long-sample bit picks the short or long sampling phase.
// [R3] After sampling, input is disconnected and successive approximation runs.
// [R4] Finished result is moved to the high and low result registers.
// [R5] Short sample, non-async clock: first conversion 20/23 clocks plus 5 bus.
// [R6] Long sample, non-async clock: first conversion 40/43 clocks plus 5 bus.
// [R7] Internal asynchronous clock adds up to 5 us startup on first conversion.
// [R8] Short sample continuous repeats take 17 or 20 conversion clocks.
// [R9] Long sample continuous repeats take 37 or 40 conversion clocks.
// [R10] Repeat sample timing not exact when bus clock is too slow.
// [R11] Compare enabled: compare value is subtracted from each result.
// [R12] Upper-limit mode sets the flag only when result >= compare value.
// [R13] Lower-limit mode sets the flag only when result < compare value.
// [R14] Flag set with interrupt enable raises the interrupt request.
// [R15] Difference is one bit wider; stored without its sign bit.
// [R16] Compare false: no flag and no result update.
// [R17] Software reads lower-limit results as negative without sign bit.
// [R18] Compare keeps monitoring in wait mode and its interrupt wakes.
// [R19] A conversion running at wait entry completes.
// [R20] In wait, hardware trigger and continuous mode still start conversions.
// [R21] Bus, halved bus and asynchronous clocks stay usable in wait.
// [R22] Completion in wait sets the flag and wakes when enabled.
// [R23] Input clock divided by 1, 2, 4 or 8 forms the conversion clock.
// [R24] Continuous mode starts a fresh conversion after each finish.
// [R25] Result rounded to 10 bits or 8 bits before storing.
// [R26] Select codes: bus, bus halved, alternate, internal asynchronous.
// [R27] Stored compare value is result plus two's complement of compare value.
`timescale 1ns/100ps
`default_nettype none
`include "cvt_regs.svh"

module cvt_top #(
  parameter int ASYNC_DIV   = 2,
  parameter int STARTUP_CYC = `CVT_ASYNC_STARTUP_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        hw_trig_i,
  input  wire logic        alt_tick_i,
  input  wire logic        comp_i,
  input  wire logic        wait_mode_i,
  output logic             irq_o,
  output logic             wake_o,
  output logic             sample_o,
  output logic      [4:0]  channel_o,
  output logic      [10:0] dac_code_o,
  output logic             conv_active_o,
  output logic             async_clk_en_o
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic       conversion_complete_flag;
  logic       complete_irq_enable;
  logic       continuous_convert_enable;
  logic [4:0] channel;
  logic       hw_trig_enable;
  logic       compare_enable;
  logic       compare_direction_select;
  logic [1:0] compare_value_high;
  logic [7:0] compare_value_low;
  logic [9:0] result;
  logic       low_power;
  logic [1:0] clock_divide_select;
  logic       long_sample_select;
  logic       ten_bit_mode;
  logic [1:0] input_clock_select;
  logic       trig_q;
  logic [5:0] cnt;

  cvt_pkg::cvt_state_e state;
  cvt_pkg::cvt_state_e next_state;

  cvt_sar_if sar ();

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Round half up, saturating at the top code of the target width
  function automatic logic [9:0] round_sat(input logic [10:0] v, input logic [9:0] top);
    logic [10:0] sum;
    sum = {1'b0, v[10:1]} + {10'h000, v[0]};
    round_sat = (sum > {1'b0, top}) ? top : sum[9:0];
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       conversion_clock_tick;
  logic       async_ready;
  logic       wr_ctrl1;
  logic       wr_setup;
  logic       channel_on;
  logic       sw_start;
  logic       hw_start;
  logic       abort;
  logic       idle;
  logic       setup_bus_done;
  logic [5:0] sample_len;
  logic [5:0] finish_len;
  logic       finish_now;
  logic [9:0] rounded;
  logic [9:0] cmp_value;
  logic [10:0] diff;
  logic       cmp_true;
  logic       keep_result;
  logic       rd_flag_clear;

  assign idle       = (state == cvt_pkg::CVT_IDLE);
  assign wr_ctrl1   = wr_i && (addr_i == `CVT_OFF_CTRL1);
  // Any configuration change makes the running conversion invalid
  assign wr_setup   = wr_i && ((addr_i == `CVT_OFF_CTRL2) || (addr_i == `CVT_OFF_CONFIG) ||
                               (addr_i == `CVT_OFF_CMP_HIGH) || (addr_i == `CVT_OFF_CMP_LOW));
  assign channel_on = (channel != `CVT_CHANNEL_OFF);
  assign sw_start   = wr_ctrl1 && (wdata_i[4:0] != `CVT_CHANNEL_OFF) && !hw_trig_enable;
  // Edges during a conversion are ignored; works in wait too  [R20]
  assign hw_start   = hw_trig_enable && channel_on && hw_trig_i && !trig_q && idle && !wr_i;
  assign abort      = wr_ctrl1 || wr_setup;

  assign setup_bus_done = (cnt >= `CVT_SETUP_BUS_CYC);
  assign sample_len = long_sample_select ? `CVT_SAMPLE_LONG : `CVT_SAMPLE_SHORT;  // [R2] [R10]
  assign finish_len = ten_bit_mode ? `CVT_FINISH_10BIT : `CVT_FINISH_8BIT;
  assign finish_now = (state == cvt_pkg::CVT_FINISH) && conversion_clock_tick && (cnt == finish_len - 6'h01);

  // 11-bit or 9-bit raw value rounded to the mode width  [R25]
  assign rounded = ten_bit_mode ? round_sat(sar.code, 10'h3ff)
                                : round_sat({2'b00, sar.code[10:2]}, 10'h0ff);

  // Result plus two's complement of compare value, one bit wider  [R11]
  assign cmp_value = ten_bit_mode ? {compare_value_high, compare_value_low} : {2'b00, compare_value_low};
  assign diff      = {1'b0, rounded} + ~{1'b0, cmp_value} + 11'h001;  // [R27]
  // Sign bit of the difference decides the outcome  [R15]
  assign cmp_true  = compare_direction_select ? !diff[10] : diff[10];  // [R12] [R13]
  assign keep_result = !compare_enable || cmp_true;  // [R16]

  assign rd_flag_clear = rd_i && (addr_i == `CVT_OFF_RESULT_LOW);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      cvt_pkg::CVT_IDLE: begin
        if (sw_start || hw_start) begin
          next_state = cvt_pkg::CVT_SETUP;
        end
      end
      cvt_pkg::CVT_SETUP: begin
        // 5 bus cycles, oscillator startup, then converter warm-up  [R5] [R6] [R7]
        if (setup_bus_done && async_ready_or_bus() && conversion_clock_tick && (cnt == `CVT_SETUP_BUS_CYC + `CVT_STARTUP_TICKS - 6'h01)) begin
          next_state = cvt_pkg::CVT_SAMPLE;
        end
      end
      cvt_pkg::CVT_SAMPLE: begin
        if (conversion_clock_tick && (cnt == sample_len - 6'h01)) begin
          next_state = cvt_pkg::CVT_CONVERT;  // [R3]
        end
      end
      cvt_pkg::CVT_CONVERT: begin
        if (sar.done) begin
          next_state = cvt_pkg::CVT_FINISH;
        end
      end
      cvt_pkg::CVT_FINISH: begin
        // Repeats skip setup; wait mode does not stop this  [R24] [R19] [R8] [R9]
        if (finish_now) begin
          next_state = continuous_convert_enable ? cvt_pkg::CVT_SAMPLE : cvt_pkg::CVT_IDLE;
        end
      end
      default: begin
        next_state = cvt_pkg::CVT_IDLE;
      end
    endcase
    if (wr_setup) begin
      next_state = cvt_pkg::CVT_IDLE;
    end
    if (wr_ctrl1) begin
      next_state = sw_start ? cvt_pkg::CVT_SETUP : cvt_pkg::CVT_IDLE;
    end
  end

  function automatic logic async_ready_or_bus();
    async_ready_or_bus = (input_clock_select != `CVT_SEL_ASYNC) || async_ready;
  endfunction

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= cvt_pkg::CVT_IDLE;
      cnt    <= 6'h00;
      trig_q <= 1'b0;
    end else if (ce_i) begin
      state  <= next_state;
      trig_q <= hw_trig_i;
      if (next_state != state || abort) begin
        cnt <= 6'h00;
      end else if (state == cvt_pkg::CVT_SETUP && !setup_bus_done) begin
        cnt <= cnt + 6'h01;
      end else if (conversion_clock_tick && state != cvt_pkg::CVT_CONVERT && !idle &&
                   (state != cvt_pkg::CVT_SETUP || async_ready_or_bus())) begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  // Sampling follows setup on a first conversion and comes first on every repeat  [R1]
  assign sample_o        = (state == cvt_pkg::CVT_SAMPLE);
  assign sar.start       = (state == cvt_pkg::CVT_SAMPLE) && (next_state == cvt_pkg::CVT_CONVERT);
  assign sar.tick        = conversion_clock_tick && (state == cvt_pkg::CVT_CONVERT);
  assign sar.comp        = comp_i;
  assign sar.ten_bit     = ten_bit_mode;
  assign dac_code_o      = sar.code;
  assign channel_o       = channel;
  assign conv_active_o   = !idle;
  // Oscillator only runs while a conversion needs it
  assign async_clk_en_o  = !idle && (input_clock_select == `CVT_SEL_ASYNC);

  // ----------------------------------------------------------------
  // Clock and approximation engine
  // ----------------------------------------------------------------
  cvt_clkgen #(
    .ASYNC_DIV   (ASYNC_DIV),
    .STARTUP_CYC (STARTUP_CYC)
  ) u_clkgen (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .ce_i          (ce_i),
    .sel_i         (input_clock_select),
    .div_i         (clock_divide_select),
    .alt_tick_i    (alt_tick_i),
    .async_en_i    (async_clk_en_o),
    .tick_o        (conversion_clock_tick),
    .async_ready_o (async_ready)
  );

  cvt_sar u_sar (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .sar     (sar.engine)
  );

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conversion_complete_flag  <= 1'b0;
      complete_irq_enable       <= 1'b0;
      continuous_convert_enable <= 1'b0;
      channel                   <= `CVT_CHANNEL_OFF;
      hw_trig_enable            <= 1'b0;
      compare_enable            <= 1'b0;
      compare_direction_select  <= 1'b0;
      compare_value_high        <= 2'h0;
      compare_value_low         <= 8'h00;
      low_power                 <= 1'b0;
      clock_divide_select       <= 2'h0;
      long_sample_select        <= 1'b0;
      ten_bit_mode              <= 1'b0;
      input_clock_select        <= 2'h0;
      result                    <= 10'h000;
    end else if (ce_i) begin
      if (wr_ctrl1) begin
        complete_irq_enable       <= wdata_i[`CVT_C1_IRQ_EN];
        continuous_convert_enable <= wdata_i[`CVT_C1_CONT];
        channel                   <= wdata_i[4:0];
      end
      if (wr_i && addr_i == `CVT_OFF_CTRL2) begin
        hw_trig_enable           <= wdata_i[`CVT_C2_HW_TRIG];
        compare_enable           <= wdata_i[`CVT_C2_CMP_EN];
        compare_direction_select <= wdata_i[`CVT_C2_CMP_DIR];
      end
      if (wr_i && addr_i == `CVT_OFF_CMP_HIGH) begin
        compare_value_high <= wdata_i[1:0];
      end
      if (wr_i && addr_i == `CVT_OFF_CMP_LOW) begin
        compare_value_low <= wdata_i;
      end
      if (wr_i && addr_i == `CVT_OFF_CONFIG) begin
        low_power           <= wdata_i[`CVT_CFG_LOW_POWER];
        clock_divide_select <= wdata_i[6:5];
        long_sample_select  <= wdata_i[`CVT_CFG_LONG_SAMPLE];
        ten_bit_mode        <= wdata_i[`CVT_CFG_TEN_BIT];
        input_clock_select  <= wdata_i[1:0];
      end
      // Completion wins over a same-cycle read clear, not over a CTRL1 write  [R18] [R22]
      if (finish_now && !abort && keep_result) begin
        result                   <= compare_enable ? (ten_bit_mode ? diff[9:0] : {2'b00, diff[7:0]})
                                                   : rounded;  // [R4] [R15]
        conversion_complete_flag <= 1'b1;
      end else if (wr_ctrl1 || rd_flag_clear) begin
        conversion_complete_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= 8'h00;
      if (rd_i) begin
        unique case (addr_i)
          `CVT_OFF_CTRL1:       rdata_o <= {conversion_complete_flag, complete_irq_enable,
                                            continuous_convert_enable, channel};
          `CVT_OFF_CTRL2:       rdata_o <= {!idle, hw_trig_enable, compare_enable,
                                            compare_direction_select, 4'h0};
          `CVT_OFF_RESULT_HIGH: rdata_o <= {6'h00, result[9:8]};
          `CVT_OFF_RESULT_LOW:  rdata_o <= result[7:0];
          `CVT_OFF_CMP_HIGH:    rdata_o <= {6'h00, compare_value_high};
          `CVT_OFF_CMP_LOW:     rdata_o <= compare_value_low;
          `CVT_OFF_CONFIG:      rdata_o <= {low_power, clock_divide_select, long_sample_select,
                                            ten_bit_mode, 1'b0, input_clock_select};
          default:              rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Level request; also the wake source in wait mode  [R14] [R22] [R18]
  assign irq_o  = conversion_complete_flag && complete_irq_enable;
  assign wake_o = irq_o && wait_mode_i;

endmodule // cvt_top

`default_nettype wire
